// ### mmr_pkg.sv
// Shared constants, register map and types of the mesh memory-mode router
package mmr_pkg;

  localparam int ADDR_W = 39;
  localparam int LINE_OFF = 6;
  localparam int TILES = 16;
  localparam int TILE_W = 4;
  localparam int DIR_SET_W = 6;
  localparam int NC_SET_W = 8;
  localparam int DIR_TAG_W = ADDR_W - LINE_OFF - DIR_SET_W;
  localparam int NC_TAG_W = ADDR_W - LINE_OFF - NC_SET_W;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  localparam logic [ADDR_W-1:0] NEAR_CAP_8G = 39'h0200000000;
  localparam logic [ADDR_W-1:0] NEAR_CAP_16G = 39'h0400000000;
  localparam logic [ADDR_W-1:0] DDR_MAX = 39'h6000000000;

  localparam int QUAD_LSB = 6;
  localparam int QSTOP_LSB = 8;
  localparam int HASH_LSB = 10;

  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_HITS = 8'h08;
  localparam logic [REG_AW-1:0] REG_MISSES = 8'h0C;
  localparam logic [REG_AW-1:0] REG_WBACKS = 8'h10;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLUS_LSB = 2;
  localparam int CTRL_CAP16_BIT = 4;
  localparam int STAT_CLUS_LSB = 0;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_UNEVEN_BIT = 3;

  typedef enum logic [1:0] {
    MEM_CACHE = 2'h0,
    MEM_FLAT = 2'h1,
    MEM_HYBRID = 2'h2
  } mmr_mem_mode_e;

  typedef enum logic [1:0] {
    CL_ANY = 2'h0,
    CL_QUAD = 2'h1,
    CL_SUB = 2'h2
  } mmr_clus_e;

  typedef enum logic [2:0] {
    COH_I = 3'h0,
    COH_S = 3'h1,
    COH_E = 3'h2,
    COH_M = 3'h3,
    COH_F = 3'h4
  } mmr_coh_e;

  typedef enum logic [1:0] {
    SRC_TILE = 2'h0,
    SRC_NEAR = 2'h1,
    SRC_DDR = 2'h2
  } mmr_src_e;

  localparam mmr_mem_mode_e CTRL_RST_MODE = MEM_CACHE;
  localparam mmr_clus_e CTRL_RST_CLUS = CL_QUAD;
  localparam logic CTRL_RST_CAP16 = 1'b1;

  typedef struct packed {
    logic vld;
    mmr_coh_e st;
    logic [TILE_W-1:0] own;
    logic [TILES-1:0] shr;
    logic [DIR_TAG_W-1:0] tag;
  } mmr_dir_s;

  typedef struct packed {
    logic vld;
    logic dirty;
    logic [NC_TAG_W-1:0] tag;
  } mmr_nct_s;

endpackage

// ### mmr_tag_ram.sv
// Small tag memory with registered read data and reset-cleared entries
`timescale 1ns/10ps
module mmr_tag_ram #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic i_clk,          // Clock
  input wire logic i_nrst,         // Synchronous reset, active low
  input wire logic i_rd_en,        // Read strobe
  input wire logic [AW-1:0] i_rd_addr, // Read index
  input wire logic i_wr_en,        // Write strobe
  input wire logic [AW-1:0] i_wr_addr, // Write index
  input wire logic [W-1:0] i_wr_data,  // Write data
  output logic [W-1:0] o_rd_data   // Read data, one cycle after strobe
);

  logic [W-1:0] mem [2**AW];
  logic [2**AW-1:0] written_ff;
  logic [2**AW-1:0] nxt_written;
  logic [W-1:0] rd_ff;
  logic [W-1:0] nxt_rd;

  // Never-written entries read as zero, so their valid bits start clear
  always_comb begin
    nxt_written = written_ff;
    nxt_rd = rd_ff;
    if (i_wr_en) begin
      nxt_written[i_wr_addr] = 1'b1;
    end
    if (i_rd_en) begin
      nxt_rd = written_ff[i_rd_addr] ? mem[i_rd_addr] : '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      written_ff <= '0;
      rd_ff <= '0;
    end else begin
      written_ff <= nxt_written;
      rd_ff <= nxt_rd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = rd_ff;

endmodule

// ### mmr_router.sv
// Mesh memory-mode router: tag directory, memory-mode decode and near-memory cache
//
// Overview of operation
// - A tile miss goes over the mesh to its home tag directory first.
// - Directory tracks each valid line in one of three coherence states: E, M or F.
// - When no tile, the requester included, caches the line, the request goes to memory.
// - Near memory capacity is 8 or 16 GB, chosen by a control bit.
// - DDR address space is limited to 384 GB; beyond that is an error.
// - Cache mode: near memory caches DDR; only DDR is addressable.
// - Flat mode: near memory and DDR occupy disjoint address ranges.
// - Hybrid mode: half of near memory caches DDR, half is addressable.
// - Any-to-any clustering: home directory hashed anywhere on the mesh.
// - Quadrant clustering: home directory in the quadrant of its memory.
// - Quadrant clustering is selected out of reset.
// - Uneven DDR population forces any-to-any clustering.
// - Both cores of a tile share one directory presence bit, one copy.
// - A line occupies one near-memory cache slot whatever tile asks.
// - Cache lookup in near memory precedes any cached DDR access; flat-mode DDR is accessed directly.
`timescale 1ns/10ps
module mmr_router (
  input wire logic i_clk,                        // Clock, 125 MHz
  input wire logic i_nrst,                       // Synchronous reset, active low
  input wire logic [mmr_pkg::REG_AW-1:0] i_reg_addr,  // Register byte address
  input wire logic [mmr_pkg::REG_DW-1:0] i_reg_wdata, // Register write data
  input wire logic i_reg_wr,                     // Register write strobe
  input wire logic i_reg_rd,                     // Register read strobe
  output logic [mmr_pkg::REG_DW-1:0] o_reg_rdata,     // Read data, cycle after strobe
  input wire logic i_ddr_uneven,                 // DDR channels populated unevenly
  input wire logic i_req_valid,                  // Tile miss request
  input wire logic [mmr_pkg::ADDR_W-1:0] i_req_addr,  // Request system address
  input wire logic i_req_write,                  // Request for ownership
  input wire logic [mmr_pkg::TILE_W-1:0] i_req_tile,  // Requesting tile
  output logic o_req_ready,                      // Router idle, request taken
  output logic [mmr_pkg::TILE_W-1:0] o_dir_stop, // Home directory mesh stop
  output logic [1:0] o_mem_quad,                 // Quadrant of the memory
  output logic o_snp_valid,                      // Snoop to tiles, held to done
  output logic o_snp_inv,                        // Snoop invalidates
  output logic [mmr_pkg::TILES-1:0] o_snp_mask,  // Snooped tiles
  input wire logic i_snp_done,                   // Snoop complete
  output logic o_near_valid,                     // Near memory access, held to done
  output logic o_near_write,                     // Near memory write
  output logic [mmr_pkg::ADDR_W-1:0] o_near_addr,     // Near memory address
  input wire logic i_near_done,                  // Near memory access complete
  output logic o_ddr_valid,                      // DDR access, held to done
  output logic o_ddr_write,                      // DDR write
  output logic [mmr_pkg::ADDR_W-1:0] o_ddr_addr,      // DDR address
  input wire logic i_ddr_done,                   // DDR access complete
  output logic o_rsp_valid,                      // Response pulse
  output logic [mmr_pkg::TILE_W-1:0] o_rsp_tile, // Response target tile
  output logic [2:0] o_rsp_state,                // Granted coherence state
  output logic [1:0] o_rsp_src,                  // Data source
  output logic o_rsp_err                         // Address outside any memory
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DIR_CHK = 4'h1,
    ST_ROUTE = 4'h3,
    ST_NC_CHK = 4'h2,
    ST_WBACK = 4'h6,
    ST_FILL = 4'h7,
    ST_MEM = 4'h5,
    ST_RESP = 4'h4,
    ST_SNOOP = 4'hC
  } mmr_state_e;

  typedef enum logic [1:0] {
    RG_NEAR = 2'h0,
    RG_DDR = 2'h1,
    RG_CACHED = 2'h2,
    RG_ERR = 2'h3
  } mmr_region_e;

  localparam int AW = mmr_pkg::ADDR_W;
  localparam int NT = mmr_pkg::TILES;

  // Configuration and register read data
  mmr_pkg::mmr_mem_mode_e mode_ff, nxt_mode;
  mmr_pkg::mmr_clus_e clus_ff, nxt_clus;
  logic cap16_ff, nxt_cap16;
  logic [mmr_pkg::REG_DW-1:0] rdata_ff, nxt_rdata;

  // Transaction state
  mmr_state_e state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic [mmr_pkg::TILE_W-1:0] tile_ff, nxt_tile;
  mmr_region_e region_ff, nxt_region;
  logic [AW-1:0] mem_addr_ff, nxt_mem_addr;
  logic [AW-1:0] nc_base_ff, nxt_nc_base;
  logic [mmr_pkg::TILE_W-1:0] stop_ff, nxt_stop;
  logic [1:0] quad_ff, nxt_quad;
  logic snp_valid_ff, nxt_snp_valid;
  logic snp_inv_ff, nxt_snp_inv;
  logic [NT-1:0] snp_mask_ff, nxt_snp_mask;
  logic then_mem_ff, nxt_then_mem;
  logic near_valid_ff, nxt_near_valid;
  logic near_write_ff, nxt_near_write;
  logic [AW-1:0] near_addr_ff, nxt_near_addr;
  logic ddr_valid_ff, nxt_ddr_valid;
  logic ddr_write_ff, nxt_ddr_write;
  logic [AW-1:0] ddr_addr_ff, nxt_ddr_addr;
  logic rsp_valid_ff, nxt_rsp_valid;
  mmr_pkg::mmr_coh_e grant_ff, nxt_grant;
  mmr_pkg::mmr_src_e src_ff, nxt_src;
  logic err_ff, nxt_err;
  mmr_pkg::mmr_dir_s new_dir_ff, nxt_new_dir;
  logic [31:0] hits_ff, nxt_hits;
  logic [31:0] misses_ff, nxt_misses;
  logic [31:0] wbacks_ff, nxt_wbacks;

  // Decode helpers
  mmr_pkg::mmr_clus_e eff_clus;
  logic [AW-1:0] cap;
  logic [AW-1:0] half_cap;
  logic [AW-1:0] flat_ddr;
  logic [AW-1:0] hyb_ddr;
  mmr_region_e acc_region;
  logic [AW-1:0] acc_mem_addr;
  logic [AW-1:0] acc_nc_base;
  logic [mmr_pkg::TILE_W-1:0] acc_stop;
  logic [NT-1:0] req_bit;
  logic [NT-1:0] own_bit;
  logic [NT-1:0] others;
  logic dir_hit;
  logic held;
  logic conflict;
  mmr_pkg::mmr_dir_s dir_q;
  mmr_pkg::mmr_dir_s mem_ent;
  mmr_pkg::mmr_nct_s nc_q;
  mmr_pkg::mmr_nct_s nc_wr_data;
  logic [AW-1:0] nc_slot;
  logic [AW-1:0] victim;
  logic dir_rd_en, dir_wr_en, nc_rd_en, nc_wr_en;
  logic [$bits(mmr_pkg::mmr_dir_s)-1:0] dir_rd_data;
  logic [$bits(mmr_pkg::mmr_nct_s)-1:0] nc_rd_data;

  assign dir_q = dir_rd_data;
  assign nc_q = nc_rd_data;

  always_comb begin
    eff_clus = i_ddr_uneven ? mmr_pkg::CL_ANY : clus_ff;
    cap = cap16_ff ? mmr_pkg::NEAR_CAP_16G : mmr_pkg::NEAR_CAP_8G;
    half_cap = cap >> 1;
    flat_ddr = i_req_addr - cap;
    hyb_ddr = i_req_addr - half_cap;
    acc_nc_base = '0;
    case (mode_ff)
      mmr_pkg::MEM_FLAT: begin
        acc_region = RG_NEAR;
        acc_mem_addr = i_req_addr;
        if (i_req_addr >= cap) begin
          acc_mem_addr = flat_ddr;
          acc_region = (flat_ddr < mmr_pkg::DDR_MAX) ? RG_DDR : RG_ERR;
        end
      end
      mmr_pkg::MEM_HYBRID: begin
        acc_region = RG_NEAR;
        acc_mem_addr = i_req_addr;
        acc_nc_base = half_cap;
        if (i_req_addr >= half_cap) begin
          acc_mem_addr = hyb_ddr;
          acc_region = (hyb_ddr < mmr_pkg::DDR_MAX) ? RG_CACHED : RG_ERR;
        end
      end
      default: begin
        acc_mem_addr = i_req_addr;
        acc_region = (i_req_addr < mmr_pkg::DDR_MAX) ? RG_CACHED : RG_ERR;
      end
    endcase
    // Home stop: hashed over the whole mesh, or kept in the memory's quadrant
    if (eff_clus == mmr_pkg::CL_ANY) begin
      acc_stop = i_req_addr[mmr_pkg::QUAD_LSB +: 4] ^ i_req_addr[mmr_pkg::HASH_LSB +: 4];
    end else begin
      acc_stop = {i_req_addr[mmr_pkg::QUAD_LSB +: 2], i_req_addr[mmr_pkg::QSTOP_LSB +: 2]};
    end
    // One presence bit per tile, whichever core asked
    req_bit = {{(NT-1){1'b0}}, 1'b1} << tile_ff;
    own_bit = {{(NT-1){1'b0}}, 1'b1} << dir_q.own;
    dir_hit = dir_q.vld && (dir_q.tag == addr_ff[AW-1 -: mmr_pkg::DIR_TAG_W]);
    held = dir_hit && dir_q.shr[tile_ff];
    others = dir_hit ? (dir_q.shr & ~req_bit) : '0;
    conflict = dir_q.vld && !dir_hit && (dir_q.shr != '0);
    mem_ent = {1'b1, wr_ff ? mmr_pkg::COH_M : mmr_pkg::COH_E, tile_ff, req_bit,
               addr_ff[AW-1 -: mmr_pkg::DIR_TAG_W]};
    nc_slot = nc_base_ff + {{(AW-mmr_pkg::NC_SET_W-mmr_pkg::LINE_OFF){1'b0}},
              mem_addr_ff[mmr_pkg::LINE_OFF +: mmr_pkg::NC_SET_W], {mmr_pkg::LINE_OFF{1'b0}}};
    victim = {nc_q.tag, mem_addr_ff[mmr_pkg::LINE_OFF +: mmr_pkg::NC_SET_W],
              {mmr_pkg::LINE_OFF{1'b0}}};
  end

  // Register port; a mode change affects only requests taken after it
  always_comb begin
    nxt_mode = mode_ff;
    nxt_clus = clus_ff;
    nxt_cap16 = cap16_ff;
    nxt_rdata = '0;
    if (i_reg_wr && (i_reg_addr == mmr_pkg::REG_CTRL)) begin
      nxt_mode = mmr_pkg::mmr_mem_mode_e'(i_reg_wdata[mmr_pkg::CTRL_MODE_LSB +: 2]);
      nxt_clus = mmr_pkg::mmr_clus_e'(i_reg_wdata[mmr_pkg::CTRL_CLUS_LSB +: 2]);
      nxt_cap16 = i_reg_wdata[mmr_pkg::CTRL_CAP16_BIT];
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        mmr_pkg::REG_CTRL: begin
          nxt_rdata[mmr_pkg::CTRL_MODE_LSB +: 2] = mode_ff;
          nxt_rdata[mmr_pkg::CTRL_CLUS_LSB +: 2] = clus_ff;
          nxt_rdata[mmr_pkg::CTRL_CAP16_BIT] = cap16_ff;
        end
        mmr_pkg::REG_STATUS: begin
          nxt_rdata[mmr_pkg::STAT_CLUS_LSB +: 2] = eff_clus;
          nxt_rdata[mmr_pkg::STAT_BUSY_BIT] = (state_ff != ST_IDLE);
          nxt_rdata[mmr_pkg::STAT_UNEVEN_BIT] = i_ddr_uneven;
        end
        mmr_pkg::REG_HITS: nxt_rdata = hits_ff;
        mmr_pkg::REG_MISSES: nxt_rdata = misses_ff;
        mmr_pkg::REG_WBACKS: nxt_rdata = wbacks_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_ff <= mmr_pkg::CTRL_RST_MODE;
      clus_ff <= mmr_pkg::CTRL_RST_CLUS;
      cap16_ff <= mmr_pkg::CTRL_RST_CAP16;
      rdata_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      clus_ff <= nxt_clus;
      cap16_ff <= nxt_cap16;
      rdata_ff <= nxt_rdata;
    end
  end

  // Transaction sequencer: one request in flight keeps the directory free of races
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wr = wr_ff;
    nxt_tile = tile_ff;
    nxt_region = region_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_nc_base = nc_base_ff;
    nxt_stop = stop_ff;
    nxt_quad = quad_ff;
    nxt_snp_valid = snp_valid_ff;
    nxt_snp_inv = snp_inv_ff;
    nxt_snp_mask = snp_mask_ff;
    nxt_then_mem = then_mem_ff;
    nxt_near_valid = near_valid_ff;
    nxt_near_write = near_write_ff;
    nxt_near_addr = near_addr_ff;
    nxt_ddr_valid = ddr_valid_ff;
    nxt_ddr_write = ddr_write_ff;
    nxt_ddr_addr = ddr_addr_ff;
    nxt_rsp_valid = 1'b0;
    nxt_grant = grant_ff;
    nxt_src = src_ff;
    nxt_err = err_ff;
    nxt_new_dir = new_dir_ff;
    nxt_hits = hits_ff;
    nxt_misses = misses_ff;
    nxt_wbacks = wbacks_ff;
    dir_rd_en = 1'b0;
    dir_wr_en = 1'b0;
    nc_rd_en = 1'b0;
    nc_wr_en = 1'b0;
    nc_wr_data = '0;
    case (state_ff)
      ST_IDLE: begin
        if (i_req_valid) begin
          dir_rd_en = 1'b1;
          nxt_addr = i_req_addr;
          nxt_wr = i_req_write;
          nxt_tile = i_req_tile;
          nxt_region = acc_region;
          nxt_mem_addr = acc_mem_addr;
          nxt_nc_base = acc_nc_base;
          nxt_stop = acc_stop;
          nxt_quad = i_req_addr[mmr_pkg::QUAD_LSB +: 2];
          nxt_err = 1'b0;
          nxt_then_mem = 1'b0;
          nxt_state = ST_DIR_CHK;
        end
      end
      ST_DIR_CHK: begin
        nxt_new_dir = mem_ent;
        nxt_grant = mem_ent.st;
        nxt_state = ST_ROUTE;
        if (conflict) begin
          // Evict the old line's holders before the slot is reused
          nxt_snp_valid = 1'b1;
          nxt_snp_inv = 1'b1;
          nxt_snp_mask = dir_q.shr;
          nxt_then_mem = 1'b1;
          nxt_state = ST_SNOOP;
        end else if (others != '0) begin
          nxt_snp_valid = 1'b1;
          nxt_snp_inv = wr_ff;
          nxt_snp_mask = wr_ff ? others : own_bit;
          nxt_src = mmr_pkg::SRC_TILE;
          nxt_grant = wr_ff ? mmr_pkg::COH_M : mmr_pkg::COH_F;
          nxt_new_dir.st = nxt_grant;
          nxt_new_dir.shr = wr_ff ? req_bit : (dir_q.shr | req_bit);
          nxt_state = ST_SNOOP;
        end else if (held) begin
          nxt_src = mmr_pkg::SRC_TILE;
          nxt_grant = wr_ff ? mmr_pkg::COH_M : dir_q.st;
          nxt_new_dir.st = nxt_grant;
          nxt_state = ST_RESP;
        end
      end
      ST_SNOOP: begin
        if (i_snp_done) begin
          nxt_snp_valid = 1'b0;
          nxt_snp_mask = '0;
          nxt_state = then_mem_ff ? ST_ROUTE : ST_RESP;
        end
      end
      ST_ROUTE: begin
        nxt_state = ST_MEM;
        case (region_ff)
          RG_CACHED: begin
            nc_rd_en = 1'b1;
            nxt_state = ST_NC_CHK;
          end
          RG_NEAR: begin
            nxt_near_valid = 1'b1;
            nxt_near_write = wr_ff;
            nxt_near_addr = mem_addr_ff;
            nxt_src = mmr_pkg::SRC_NEAR;
          end
          RG_DDR: begin
            nxt_ddr_valid = 1'b1;
            nxt_ddr_write = wr_ff;
            nxt_ddr_addr = mem_addr_ff;
            nxt_src = mmr_pkg::SRC_DDR;
          end
          default: begin
            nxt_err = 1'b1;
            nxt_state = ST_RESP;
          end
        endcase
      end
      ST_NC_CHK: begin
        nxt_src = mmr_pkg::SRC_DDR;
        if (nc_q.vld && (nc_q.tag == mem_addr_ff[AW-1 -: mmr_pkg::NC_TAG_W])) begin
          nxt_hits = hits_ff + 32'h1;
          nc_wr_en = 1'b1;
          nc_wr_data = {1'b1, nc_q.dirty | wr_ff, nc_q.tag};
          nxt_near_valid = 1'b1;
          nxt_near_write = wr_ff;
          nxt_near_addr = nc_slot;
          nxt_src = mmr_pkg::SRC_NEAR;
          nxt_state = ST_MEM;
        end else if (nc_q.vld && nc_q.dirty) begin
          nxt_misses = misses_ff + 32'h1;
          nxt_wbacks = wbacks_ff + 32'h1;
          nxt_ddr_valid = 1'b1;
          nxt_ddr_write = 1'b1;
          nxt_ddr_addr = victim;
          nxt_state = ST_WBACK;
        end else begin
          nxt_misses = misses_ff + 32'h1;
          nxt_state = ST_FILL;
        end
      end
      ST_WBACK: begin
        if (i_ddr_done) begin
          nxt_ddr_valid = 1'b0;
          nxt_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (!ddr_valid_ff) begin
          nxt_ddr_valid = 1'b1;
          nxt_ddr_write = 1'b0;
          nxt_ddr_addr = mem_addr_ff;
        end else if (i_ddr_done) begin
          nxt_ddr_valid = 1'b0;
          nc_wr_en = 1'b1;
          nc_wr_data = {1'b1, wr_ff, mem_addr_ff[AW-1 -: mmr_pkg::NC_TAG_W]};
          nxt_near_valid = 1'b1;
          nxt_near_write = 1'b1;
          nxt_near_addr = nc_slot;
          nxt_state = ST_MEM;
        end
      end
      ST_MEM: begin
        if (near_valid_ff ? i_near_done : i_ddr_done) begin
          nxt_near_valid = 1'b0;
          nxt_ddr_valid = 1'b0;
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        nxt_rsp_valid = 1'b1;
        dir_wr_en = !err_ff;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_ready = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b1;
      addr_ff <= '0;
      wr_ff <= 1'b0;
      tile_ff <= '0;
      region_ff <= RG_NEAR;
      mem_addr_ff <= '0;
      nc_base_ff <= '0;
      stop_ff <= '0;
      quad_ff <= '0;
      snp_valid_ff <= 1'b0;
      snp_inv_ff <= 1'b0;
      snp_mask_ff <= '0;
      then_mem_ff <= 1'b0;
      near_valid_ff <= 1'b0;
      near_write_ff <= 1'b0;
      near_addr_ff <= '0;
      ddr_valid_ff <= 1'b0;
      ddr_write_ff <= 1'b0;
      ddr_addr_ff <= '0;
      rsp_valid_ff <= 1'b0;
      grant_ff <= mmr_pkg::COH_I;
      src_ff <= mmr_pkg::SRC_TILE;
      err_ff <= 1'b0;
      new_dir_ff <= '0;
      hits_ff <= '0;
      misses_ff <= '0;
      wbacks_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      tile_ff <= nxt_tile;
      region_ff <= nxt_region;
      mem_addr_ff <= nxt_mem_addr;
      nc_base_ff <= nxt_nc_base;
      stop_ff <= nxt_stop;
      quad_ff <= nxt_quad;
      snp_valid_ff <= nxt_snp_valid;
      snp_inv_ff <= nxt_snp_inv;
      snp_mask_ff <= nxt_snp_mask;
      then_mem_ff <= nxt_then_mem;
      near_valid_ff <= nxt_near_valid;
      near_write_ff <= nxt_near_write;
      near_addr_ff <= nxt_near_addr;
      ddr_valid_ff <= nxt_ddr_valid;
      ddr_write_ff <= nxt_ddr_write;
      ddr_addr_ff <= nxt_ddr_addr;
      rsp_valid_ff <= nxt_rsp_valid;
      grant_ff <= nxt_grant;
      src_ff <= nxt_src;
      err_ff <= nxt_err;
      new_dir_ff <= nxt_new_dir;
      hits_ff <= nxt_hits;
      misses_ff <= nxt_misses;
      wbacks_ff <= nxt_wbacks;
    end
  end

  mmr_tag_ram #(.W($bits(mmr_pkg::mmr_dir_s)), .AW(mmr_pkg::DIR_SET_W)) u_dir (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rd_en(dir_rd_en),
    .i_rd_addr(i_req_addr[mmr_pkg::LINE_OFF +: mmr_pkg::DIR_SET_W]),
    .i_wr_en(dir_wr_en),
    .i_wr_addr(addr_ff[mmr_pkg::LINE_OFF +: mmr_pkg::DIR_SET_W]),
    .i_wr_data(new_dir_ff),
    .o_rd_data(dir_rd_data)
  );

  mmr_tag_ram #(.W($bits(mmr_pkg::mmr_nct_s)), .AW(mmr_pkg::NC_SET_W)) u_nct (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rd_en(nc_rd_en),
    .i_rd_addr(mem_addr_ff[mmr_pkg::LINE_OFF +: mmr_pkg::NC_SET_W]),
    .i_wr_en(nc_wr_en),
    .i_wr_addr(mem_addr_ff[mmr_pkg::LINE_OFF +: mmr_pkg::NC_SET_W]),
    .i_wr_data(nc_wr_data),
    .o_rd_data(nc_rd_data)
  );

  assign o_reg_rdata = rdata_ff;
  assign o_req_ready = ready_ff;
  assign o_dir_stop = stop_ff;
  assign o_mem_quad = quad_ff;
  assign o_snp_valid = snp_valid_ff;
  assign o_snp_inv = snp_inv_ff;
  assign o_snp_mask = snp_mask_ff;
  assign o_near_valid = near_valid_ff;
  assign o_near_write = near_write_ff;
  assign o_near_addr = near_addr_ff;
  assign o_ddr_valid = ddr_valid_ff;
  assign o_ddr_write = ddr_write_ff;
  assign o_ddr_addr = ddr_addr_ff;
  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp_tile = tile_ff;
  assign o_rsp_state = grant_ff;
  assign o_rsp_src = src_ff;
  assign o_rsp_err = err_ff;

endmodule

// ### mmr_far_model.sv
// Far-side responder: answers a held request with a done pulse after a delay
`timescale 1ns/10ps
module mmr_far_model (
  input wire logic i_clk,       // Clock
  input wire logic i_valid,     // Held request
  input wire logic [3:0] i_dly, // Wait before answering
  output logic o_done           // Completion pulse
);
  logic [4:0] cnt_ff;
  // Count clears between requests so each one waits its full delay
  always_ff @(posedge i_clk) cnt_ff <= i_valid ? cnt_ff + 5'h1 : 5'h0;
  assign o_done = i_valid && cnt_ff == {1'b0, i_dly};
endmodule

// ### mmr_router_chk.sv
// Assertion checker for the mesh memory-mode router
`timescale 1ns/10ps
module mmr_router_chk (
  input wire logic i_clk, i_nrst, i_reg_wr, i_ddr_uneven, i_req_valid, o_req_ready,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [38:0] i_req_addr,
  input wire logic [3:0] o_dir_stop,
  input wire logic [1:0] o_mem_quad,
  input wire logic [15:0] o_snp_mask,
  input wire logic o_snp_valid, o_snp_inv, o_near_valid, i_near_done,
  input wire logic o_ddr_valid, i_ddr_done, o_rsp_valid, o_rsp_err
);
  logic [38:0] a_ff;
  logic [1:0] c_ff;
  logic u_ff, q_ff;
  wire logic acc = i_req_valid && o_req_ready;
  // Routing inputs are frozen at acceptance, as mode changes apply to later requests
  always_ff @(posedge i_clk) begin
    if (!i_nrst)
      c_ff <= 2'h1;
    else if (i_reg_wr && i_reg_addr == 8'h00)
      c_ff <= i_reg_wdata[3:2];
    if (acc) begin
      a_ff <= i_req_addr;
      u_ff <= i_ddr_uneven;
      q_ff <= c_ff != 2'h0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_dir_first: assert property (acc |=> !(o_snp_valid || o_near_valid || o_ddr_valid))
    else $error("access before directory check");
  a_fwd_owner: assert property (o_snp_valid && !o_snp_inv |-> $onehot(o_snp_mask))
    else $error("forward snoop not one owner");
  a_err_range: assert property (o_rsp_valid && a_ff >= 39'h6400000000 |-> o_rsp_err)
    else $error("range error missed");
  a_near_hold: assert property (o_near_valid && !i_near_done |=> o_near_valid)
    else $error("near access dropped");
  a_ddr_hold: assert property (o_ddr_valid && !i_ddr_done |=> o_ddr_valid)
    else $error("ddr access dropped");
  a_quad_home: assert property (o_rsp_valid && q_ff && !u_ff |->
    o_dir_stop == {a_ff[7:6], a_ff[9:8]} && o_mem_quad == a_ff[7:6])
    else $error("quadrant home wrong");
  a_any_home: assert property (o_rsp_valid && (u_ff || !q_ff) |->
    o_dir_stop == (a_ff[9:6] ^ a_ff[13:10]))
    else $error("hashed home wrong");
  a_rsp_pulse: assert property (o_rsp_valid |-> o_req_ready ##1 !o_rsp_valid)
    else $error("response not a pulse");
endmodule
bind mmr_router mmr_router_chk i_chk (.i_clk, .i_nrst, .i_reg_wr, .i_ddr_uneven,
  .i_req_valid, .o_req_ready, .i_reg_addr, .i_reg_wdata, .i_req_addr, .o_dir_stop,
  .o_mem_quad, .o_snp_mask, .o_snp_valid, .o_snp_inv, .o_near_valid, .i_near_done,
  .o_ddr_valid, .i_ddr_done, .o_rsp_valid, .o_rsp_err);

// ### mmr_router_bench.sv
// Directed bench for the mesh memory-mode router
`timescale 1ns/10ps
module mmr_router_bench;
  logic i_clk = 0, i_nrst = 0, wr_s = 0, rd_s = 0, unev = 0, qv = 0, qw = 0;
  logic sd, nd, dd, sv, nv, dv, rv, rdy, err, nw, dw;
  logic [7:0] ra = 0;
  logic [31:0] wd = 0, rdata;
  logic [38:0] qa = 0, na, da;
  logic [3:0] qt = 0, dly = 0, tile;
  logic [2:0] st;
  logic [1:0] src;
  int errors = 0, n_checks = 0;
  mmr_router i_mmr_router (.i_clk, .i_nrst, .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_ddr_uneven(unev),
    .i_req_valid(qv), .i_req_addr(qa), .i_req_write(qw), .i_req_tile(qt), .o_req_ready(rdy),
    .o_dir_stop(), .o_mem_quad(), .o_snp_valid(sv), .o_snp_inv(), .o_snp_mask(),
    .i_snp_done(sd), .o_near_valid(nv), .o_near_write(nw), .o_near_addr(na), .i_near_done(nd),
    .o_ddr_valid(dv), .o_ddr_write(dw), .o_ddr_addr(da), .i_ddr_done(dd), .o_rsp_valid(rv),
    .o_rsp_tile(tile), .o_rsp_state(st), .o_rsp_src(src), .o_rsp_err(err));
  mmr_far_model i_snp (.i_clk, .i_valid(sv), .i_dly(dly), .o_done(sd));
  mmr_far_model i_near (.i_clk, .i_valid(nv), .i_dly(dly), .o_done(nd));
  mmr_far_model i_ddr (.i_clk, .i_valid(dv), .i_dly(dly), .o_done(dd));
  initial forever #4 i_clk = ~i_clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    ra <= a;
    wd <= d;
    wr_s <= 1;
    @(posedge i_clk) wr_s <= 0;
    @(posedge i_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    ra <= a;
    rd_s <= 1;
    @(posedge i_clk) rd_s <= 0;
    #1 chk("rdata", e, rdata);
    @(posedge i_clk);
  endtask
  // Error responses carry no meaningful state or source
  task automatic req(logic [38:0] a, logic w, logic [3:0] t, logic [2:0] es, logic [1:0] ec,
    logic ee);
    qa <= a;
    qw <= w;
    qt <= t;
    qv <= 1;
    @(posedge i_clk) qv <= 0;
    for (int i = 0; i < 300 && rv !== 1'b1; i++) @(posedge i_clk) #1;
    if (rv !== 1'b1) begin
      chk("rsp_valid", 32'h1, rv);
      complete_run;
    end else begin
      chk("err", ee, err);
      chk("tile", t, tile);
      chk("ready", 32'h1, rdy);
      if (!ee) begin
        chk("state", es, st);
        chk("src", ec, src);
      end
      @(posedge i_clk);
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1;
    @(posedge i_clk);
    rd(8'h04, 32'h1);
    rd(8'h00, 32'h14);
    rd(8'h20, 32'h0);
    req(39'h1000, 0, 0, 3'h2, 2'h2, 0);
    req(39'h1000, 0, 0, 3'h2, 2'h0, 0);
    dly <= 5;
    req(39'h1000, 0, 1, 3'h4, 2'h0, 0);
    req(39'h1000, 1, 2, 3'h3, 2'h0, 0);
    req(39'h2000, 1, 0, 3'h3, 2'h2, 0);
    req(39'h1000, 1, 3, 3'h3, 2'h1, 0);
    req(39'h5000, 0, 4, 3'h2, 2'h2, 0);
    rd(8'h08, 32'h1);
    rd(8'h0C, 32'h3);
    rd(8'h10, 32'h1);
    wr(8'h00, 32'h15);
    req(39'h100, 0, 5, 3'h2, 2'h1, 0);
    req(39'h6400000000, 0, 6, 3'h0, 2'h0, 1);
    wr(8'h00, 32'h05);
    req(39'h200000040, 0, 7, 3'h2, 2'h2, 0);
    chk("ddr_addr", 32'h1, da[37:6]);
    wr(8'h00, 32'h1A);
    req(39'h140, 0, 8, 3'h2, 2'h1, 0);
    chk("near_addr", 32'h5, na[37:6]);
    unev <= 1;
    rd(8'h04, 32'h8);
    req(39'h400000000, 0, 9, 3'h2, 2'h2, 0);
    chk("ddr_addr", 32'h08000000, da[37:6]);
    chk("near_addr", 32'h08000000, na[37:6]);
    chk("wr_flags", 32'h1, {dw, nw});
    complete_run;
  end
endmodule
